// ---- design/shadow_reg.v ----
// buffered value with an active copy loaded on the update event
// assumes: single clock, asynchronous active-low reset
`timescale 1ns/1ps
module shadow_reg #(
   parameter WIDTH = 16,
   parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b0}}
) (
   input wire clock_in,
   input wire reset_n_in,
   input wire write_in,
   input wire [WIDTH-1:0] data_in,
   input wire buf_en_in,
   input wire update_in,
   output wire [WIDTH-1:0] buffer_out,
   output wire [WIDTH-1:0] active_out
);
   reg [WIDTH-1:0] buffer_reg;
   reg [WIDTH-1:0] active_reg;

   // ==========================================================
   // buffer and active copy
   always @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         buffer_reg <= RESET_VALUE;
         active_reg <= RESET_VALUE;
      end else begin
         if (write_in)
            buffer_reg <= data_in;
         if (write_in && !buf_en_in)
            active_reg <= data_in; // R1
         else if (update_in)
            active_reg <= write_in ? data_in : buffer_reg; // R5
      end
   end

   assign buffer_out = buffer_reg;
   assign active_out = active_reg;
endmodule

// ---- design/timer_compare_pwm.v ----
// timer counter with one compare channel: compare, pwm and single shot
// assumes: apb slave at 100 MHz, trigger input synchronous to clock_in
`timescale 1ns/1ps
`include "timer_pwm_regs.vh"

// Operation
// R1: unbuffered compare writes apply at once
// R2: toggle mode inverts output on match
// R3: codes 110 and 111 select pwm 1/2
// R4: reload sets period, compare sets duty
// R5: update event or forced update loads copies
// R6: output polarity selectable high or low
// R7: output reaches pin only when enabled
// R8: pwm reference changes on compare change only; code also sets it when a mode write leaves frozen for pwm
// R9: align zero edge, nonzero center, same waveform
// R10: edge mode direction bit low counts up
// R11: pwm1 up: high below compare, limits
// R12: pwm1 down: low above compare
// R13: center mode flags by alignment field
// R14: hardware owns direction in center mode
// R15: software never writes direction with alignment
// R16: center counter write above reload keeps direction
// R17: center write zero/reload sets direction, no update
// R18: single shot stops counter at update event
// R19: software sets legal start before trigger
// R20: single shot pwm2 rises at match, falls at reload
// R21: trigger mode edge on input2 starts counter
// R22: software enables buffering for pwm
// R23: polarity zero follows reference, else inverted
// R24: match actions frozen, active, inactive, toggle
// R25: disabled output shows inactive level
module timer_compare_pwm #(
   parameter WIDTH = 16
) (
   input wire clock_in,
   input wire reset_n_in,
   input wire psel_in,
   input wire penable_in,
   input wire pwrite_in,
   input wire [11:0] paddr_in,
   input wire [31:0] pwdata_in,
   output wire pready_out,
   output wire pslverr_out,
   output reg [31:0] prdata_out,
   input wire input2_filtered_edge_in,
   output reg channel_out,
   output reg channel_oe_out,
   output reg compare_flag_out
);
   // ==========================================================
   // apb decode
   wire access_w = psel_in && penable_in;
   wire wr_w = access_w && pwrite_in;
   wire mapped_w = (paddr_in == `CTRL_OFFSET) || (paddr_in == `MODE_OFFSET) ||
      (paddr_in == `RELOAD_OFFSET) || (paddr_in == `COMPARE_OFFSET) ||
      (paddr_in == `COUNT_OFFSET) || (paddr_in == `EVENT_OFFSET) ||
      (paddr_in == `STATUS_OFFSET);
   assign pready_out = 1'b1;
   assign pslverr_out = access_w && !mapped_w;
   wire wr_ctrl_w = wr_w && (paddr_in == `CTRL_OFFSET);
   wire wr_mode_w = wr_w && (paddr_in == `MODE_OFFSET);
   wire wr_reload_w = wr_w && (paddr_in == `RELOAD_OFFSET);
   wire wr_compare_w = wr_w && (paddr_in == `COMPARE_OFFSET);
   wire wr_count_w = wr_w && (paddr_in == `COUNT_OFFSET);
   wire wr_event_w = wr_w && (paddr_in == `EVENT_OFFSET);
   wire rd_status_w = access_w && !pwrite_in && (paddr_in == `STATUS_OFFSET);

   // ==========================================================
   // control state
   reg counter_run_reg;
   reg count_direction_reg;
   reg single_shot_reg;
   reg reload_buf_en_reg;
   reg [1:0] align_sel_reg;
   reg [2:0] compare_mode_sel_reg;
   reg compare_buf_en_reg;
   reg out_polarity_reg;
   reg out_enable_reg;
   reg [2:0] slave_mode_sel_reg;
   reg [2:0] trigger_source_sel_reg;
   reg [WIDTH-1:0] count_value_reg;
   reg ref_wave_reg;
   reg cmp_result_reg;
   reg trig_prev_reg;

   wire [WIDTH-1:0] reload_value_w;
   wire [WIDTH-1:0] compare_value_w;
   wire [WIDTH-1:0] reload_buf_w;
   wire [WIDTH-1:0] compare_buf_w;
   wire center_w = (align_sel_reg != `ALIGN_EDGE); // R9
   wire force_update_w = wr_event_w && pwdata_in[`EVENT_UPDATE_BIT];

   // ==========================================================
   // counter step and update event
   reg [WIDTH-1:0] count_next;
   reg direction_next;
   reg overflow_w;
   always @* begin
      count_next = count_value_reg;
      direction_next = count_direction_reg;
      overflow_w = 1'b0;
      if (counter_run_reg) begin
         if (!center_w) begin
            if (!count_direction_reg) begin // R10
               if (count_value_reg >= reload_value_w) begin
                  count_next = {WIDTH{1'b0}};
                  overflow_w = 1'b1;
               end else
                  count_next = count_value_reg + 1'b1;
            end else begin
               if (count_value_reg == {WIDTH{1'b0}}) begin
                  count_next = reload_value_w;
                  overflow_w = 1'b1;
               end else
                  count_next = count_value_reg - 1'b1;
            end
         end else begin
            if (!count_direction_reg) begin // R14
               if (count_value_reg + 1'b1 >= reload_value_w) begin
                  count_next = reload_value_w;
                  direction_next = 1'b1;
                  overflow_w = 1'b1;
               end else
                  count_next = count_value_reg + 1'b1;
            end else begin
               if (count_value_reg <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
                  count_next = {WIDTH{1'b0}};
                  direction_next = 1'b0;
                  overflow_w = 1'b1;
               end else
                  count_next = count_value_reg - 1'b1;
            end
         end
      end
   end
   wire update_event_w = overflow_w || force_update_w; // R5

   // ==========================================================
   // buffered reload and compare
   shadow_reg #(
      .WIDTH(WIDTH),
      .RESET_VALUE(`RELOAD_RESET)
   ) reload_copy (
      .clock_in(clock_in),
      .reset_n_in(reset_n_in),
      .write_in(wr_reload_w),
      .data_in(pwdata_in[WIDTH-1:0]),
      .buf_en_in(reload_buf_en_reg),
      .update_in(update_event_w),
      .buffer_out(reload_buf_w),
      .active_out(reload_value_w)
   );
   shadow_reg #(
      .WIDTH(WIDTH),
      .RESET_VALUE(`COMPARE_RESET)
   ) compare_copy (
      .clock_in(clock_in),
      .reset_n_in(reset_n_in),
      .write_in(wr_compare_w),
      .data_in(pwdata_in[WIDTH-1:0]),
      .buf_en_in(compare_buf_en_reg),
      .update_in(update_event_w),
      .buffer_out(compare_buf_w),
      .active_out(compare_value_w)
   );

   // ==========================================================
   // trigger start
   wire trig_edge_w = input2_filtered_edge_in && !trig_prev_reg;
   wire trig_start_w = (slave_mode_sel_reg == `SLAVE_TRIGGER) &&
      (trigger_source_sel_reg == `TRIG_INPUT2) && trig_edge_w; // R21

   // ==========================================================
   // compare logic
   wire match_w = counter_run_reg && (count_value_reg == compare_value_w);
   wire ahead_w = count_direction_reg ?
      (count_value_reg > compare_value_w) : // R12
      (count_value_reg >= compare_value_w); // R11
   // pwm1 reference level, held high when compare exceeds reload
   wire pwm1_level_w = (compare_value_w > reload_value_w) ? 1'b1 : !ahead_w; // R4
   wire is_pwm_w = (compare_mode_sel_reg == `CMP_PWM1) ||
      (compare_mode_sel_reg == `CMP_PWM2); // R3
   wire [2:0] new_mode_w = pwdata_in[`MODE_CMP_MSB:`MODE_CMP_LSB];
   wire leave_frozen_w = wr_mode_w && (compare_mode_sel_reg == `CMP_FROZEN) &&
      ((new_mode_w == `CMP_PWM1) || (new_mode_w == `CMP_PWM2));
   wire flag_dir_ok_w = !center_w ||
      (align_sel_reg == `ALIGN_CENTER_BOTH) ||
      ((align_sel_reg == `ALIGN_CENTER_DOWN) && count_direction_reg) ||
      ((align_sel_reg == `ALIGN_CENTER_UP) && !count_direction_reg); // R13

   always @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         ref_wave_reg <= 1'b0;
         cmp_result_reg <= 1'b0;
      end else begin
         cmp_result_reg <= pwm1_level_w;
         if (leave_frozen_w)
            ref_wave_reg <= (new_mode_w == `CMP_PWM2) ? !pwm1_level_w : pwm1_level_w; // R8
         else begin
            case (compare_mode_sel_reg)
               `CMP_ACTIVE: if (match_w) ref_wave_reg <= 1'b1; // R24
               `CMP_INACTIVE: if (match_w) ref_wave_reg <= 1'b0; // R24
               `CMP_TOGGLE: if (match_w) ref_wave_reg <= !ref_wave_reg; // R2
               `CMP_FORCE_LOW: ref_wave_reg <= 1'b0;
               `CMP_FORCE_HIGH: ref_wave_reg <= 1'b1;
               `CMP_PWM1: if (pwm1_level_w != cmp_result_reg) ref_wave_reg <= pwm1_level_w; // R8
               `CMP_PWM2: if (pwm1_level_w != cmp_result_reg)
                  ref_wave_reg <= !pwm1_level_w; // R20
               default: ref_wave_reg <= ref_wave_reg; // R24
            endcase
         end
      end
   end

   // ==========================================================
   // register writes and counter
   always @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         counter_run_reg <= 1'b0;
         count_direction_reg <= 1'b0;
         single_shot_reg <= 1'b0;
         reload_buf_en_reg <= 1'b0;
         align_sel_reg <= `ALIGN_EDGE;
         compare_mode_sel_reg <= `CMP_FROZEN;
         compare_buf_en_reg <= 1'b0;
         out_polarity_reg <= 1'b0;
         out_enable_reg <= 1'b0;
         slave_mode_sel_reg <= 3'h0;
         trigger_source_sel_reg <= 3'h0;
         count_value_reg <= {WIDTH{1'b0}};
         trig_prev_reg <= 1'b0;
         compare_flag_out <= 1'b0;
      end else begin
         trig_prev_reg <= input2_filtered_edge_in;
         count_value_reg <= count_next;
         count_direction_reg <= direction_next;
         if (overflow_w && single_shot_reg)
            counter_run_reg <= 1'b0; // R18
         if (trig_start_w)
            counter_run_reg <= 1'b1; // R21
         if (wr_ctrl_w) begin
            counter_run_reg <= pwdata_in[`CTRL_RUN_BIT];
            single_shot_reg <= pwdata_in[`CTRL_SHOT_BIT];
            reload_buf_en_reg <= pwdata_in[`CTRL_RBUF_BIT];
            align_sel_reg <= pwdata_in[`CTRL_ALIGN_MSB:`CTRL_ALIGN_LSB];
            // center mode keeps hardware direction
            if (!center_w)
               count_direction_reg <= pwdata_in[`CTRL_DIR_BIT]; // R14
         end
         if (wr_mode_w) begin
            compare_mode_sel_reg <= new_mode_w;
            compare_buf_en_reg <= pwdata_in[`MODE_CBUF_BIT];
            out_polarity_reg <= pwdata_in[`MODE_POL_BIT];
            out_enable_reg <= pwdata_in[`MODE_OEN_BIT];
            slave_mode_sel_reg <= pwdata_in[`MODE_SLAVE_MSB:`MODE_SLAVE_LSB];
            trigger_source_sel_reg <= pwdata_in[`MODE_TRIG_MSB:`MODE_TRIG_LSB];
         end
         if (force_update_w)
            count_value_reg <= count_direction_reg ? reload_buf_w : {WIDTH{1'b0}};
         if (wr_count_w) begin
            count_value_reg <= pwdata_in[WIDTH-1:0];
            if (center_w && (pwdata_in[WIDTH-1:0] == {WIDTH{1'b0}}))
               count_direction_reg <= 1'b0; // R17
            else if (center_w && (pwdata_in[WIDTH-1:0] == reload_value_w))
               count_direction_reg <= 1'b1; // R17
            else if (center_w)
               count_direction_reg <= count_direction_reg; // R16
         end
         // set wins over read clear
         if (match_w && flag_dir_ok_w)
            compare_flag_out <= 1'b1;
         else if (rd_status_w)
            compare_flag_out <= 1'b0;
      end
   end

   // ==========================================================
   // pin driver
   always @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         channel_out <= 1'b0;
         channel_oe_out <= 1'b0;
      end else begin
         channel_oe_out <= out_enable_reg; // R7
         if (out_enable_reg)
            channel_out <= ref_wave_reg ^ out_polarity_reg; // R6 R23
         else
            channel_out <= out_polarity_reg; // R25
      end
   end

   // ==========================================================
   // read mux
   always @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in)
         prdata_out <= 32'h00000000;
      else if (psel_in && !penable_in && !pwrite_in) begin
         prdata_out <= 32'h00000000;
         case (paddr_in)
            `CTRL_OFFSET: prdata_out <= {26'h0000000, align_sel_reg, reload_buf_en_reg,
               single_shot_reg, count_direction_reg, counter_run_reg};
            `MODE_OFFSET: prdata_out <= {17'h00000, trigger_source_sel_reg, 1'b0,
               slave_mode_sel_reg, 2'h0, out_enable_reg, out_polarity_reg,
               compare_buf_en_reg, compare_mode_sel_reg};
            `RELOAD_OFFSET: prdata_out <= {{(32-WIDTH){1'b0}}, reload_buf_w};
            `COMPARE_OFFSET: prdata_out <= {{(32-WIDTH){1'b0}}, compare_buf_w};
            `COUNT_OFFSET: prdata_out <= {{(32-WIDTH){1'b0}}, count_value_reg};
            `STATUS_OFFSET: prdata_out <= {28'h0000000, counter_run_reg,
               count_direction_reg, ref_wave_reg, compare_flag_out};
            default: prdata_out <= 32'h00000000;
         endcase
      end
   end
endmodule

// ---- shared/timer_pwm_regs.vh ----
// register offsets, field codes and reset values of the timer channel
// assumes: included by design files, 32-bit apb data, byte addresses
`ifndef TIMER_PWM_REGS_VH
`define TIMER_PWM_REGS_VH

`define CTRL_OFFSET 12'h000
`define MODE_OFFSET 12'h004
`define RELOAD_OFFSET 12'h008
`define COMPARE_OFFSET 12'h00C
`define COUNT_OFFSET 12'h010
`define EVENT_OFFSET 12'h014
`define STATUS_OFFSET 12'h018

// ctrl register fields
`define CTRL_RUN_BIT 0
`define CTRL_DIR_BIT 1
`define CTRL_SHOT_BIT 2
`define CTRL_RBUF_BIT 3
`define CTRL_ALIGN_LSB 4
`define CTRL_ALIGN_MSB 5
// mode register fields
`define MODE_CMP_LSB 0
`define MODE_CMP_MSB 2
`define MODE_CBUF_BIT 3
`define MODE_POL_BIT 4
`define MODE_OEN_BIT 5
`define MODE_SLAVE_LSB 8
`define MODE_SLAVE_MSB 10
`define MODE_TRIG_LSB 12
`define MODE_TRIG_MSB 14
// event register fields
`define EVENT_UPDATE_BIT 0
// status register fields
`define STATUS_FLAG_BIT 0
`define STATUS_REF_BIT 1
`define STATUS_DIR_BIT 2
`define STATUS_RUN_BIT 3

// compare mode codes
`define CMP_FROZEN 3'h0
`define CMP_ACTIVE 3'h1
`define CMP_INACTIVE 3'h2
`define CMP_TOGGLE 3'h3
`define CMP_FORCE_LOW 3'h4
`define CMP_FORCE_HIGH 3'h5
`define CMP_PWM1 3'h6
`define CMP_PWM2 3'h7
// alignment codes
`define ALIGN_EDGE 2'h0
`define ALIGN_CENTER_DOWN 2'h1
`define ALIGN_CENTER_UP 2'h2
`define ALIGN_CENTER_BOTH 2'h3
// slave mode and trigger source codes
`define SLAVE_TRIGGER 3'h6
`define TRIG_INPUT2 3'h6

// reset values
`define RELOAD_RESET 16'hFFFF
`define COMPARE_RESET 16'h0000

`endif

// ---- test/timer_compare_pwm_onepulse_tb.sv ----
// self-checking bench for the timer channel
// assumes: trig_partner model, timer_pwm_regs.vh on include path
`timescale 1ns/1ps
`include "timer_pwm_regs.vh"
module timer_compare_pwm_onepulse_tb;
   reg clock_in = 1'b0;
   reg reset_n_in = 1'b0;
   reg psel_in = 1'b0;
   reg penable_in = 1'b0;
   reg pwrite_in = 1'b0;
   reg [11:0] paddr_in = 12'h000;
   reg [31:0] pwdata_in = 32'h00000000;
   reg fire = 1'b0;
   reg [31:0] seed = 32'h5D0FF7F9;
   reg [31:0] rdata;
   reg [31:0] mv;
   reg err;
   reg [14:0] acts = 15'h214C;
   reg [4:0] exp5 = 5'b01110;
   wire [31:0] prdata_out;
   wire pready_out, pslverr_out, trig, channel_out, channel_oe_out, compare_flag_out;
   integer n_mismatch = 0;
   integer n_checks = 0;
   integer i, h, t;
   always #5 clock_in = ~clock_in;
   timer_compare_pwm #(.WIDTH(16)) u_timer_compare_pwm (.clock_in(clock_in),
      .reset_n_in(reset_n_in), .psel_in(psel_in), .penable_in(penable_in),
      .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
      .pready_out(pready_out), .pslverr_out(pslverr_out), .prdata_out(prdata_out),
      .input2_filtered_edge_in(trig), .channel_out(channel_out),
      .channel_oe_out(channel_oe_out), .compare_flag_out(compare_flag_out));
   trig_partner u_trig_partner (.clock_in(clock_in), .fire_in(fire), .trig_out(trig));
   // ====================
   // tasks and model
   function [31:0] xs(input [31:0] s);
      reg [31:0] x;
      begin
         x = s ^ (s << 13);
         x = x ^ (x >> 17);
         xs = x ^ (x << 5);
      end
   endfunction
   function integer model_high(input [2:0] m, input d, input integer c);
      integer p;
      begin
         p = d ? ((c > 9) ? 10 : c + 1) : ((c > 10) ? 10 : c);
         if (m == `CMP_PWM2) p = 10 - p;
         model_high = 10 * p;
      end
   endfunction
   task check(input [31:0] got, input [31:0] exp);
      begin
         n_checks = n_checks + 1;
         if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task close_out;
      begin
         $display("checks %0d mismatches %0d", n_checks, n_mismatch);
         if (n_mismatch == 0 && n_checks > 0)
            $display("Simulation passed");
         else
            $display("Simulation failed");
         $finish;
      end
   endtask
   task apb(input wr, input [11:0] a, input [31:0] d);
      begin
         @(posedge clock_in);
         psel_in <= 1'b1;
         pwrite_in <= wr;
         paddr_in <= a;
         pwdata_in <= d;
         @(posedge clock_in);
         penable_in <= 1'b1;
         @(posedge clock_in);
         while (pready_out !== 1'b1)
            @(posedge clock_in);
         rdata = prdata_out;
         err = pslverr_out;
         psel_in <= 1'b0;
         penable_in <= 1'b0;
      end
   endtask
   task watch(input integer n);
      reg last;
      begin
         h = 0;
         t = 0;
         @(negedge clock_in);
         last = channel_out;
         repeat (n) begin
            @(negedge clock_in);
            if (channel_out === 1'b1) h = h + 1;
            if (channel_out !== last) t = t + 1;
            last = channel_out;
         end
      end
   endtask
   task pin_is(input e);
      begin
         repeat (4) @(negedge clock_in);
         check(channel_out, e);
      end
   endtask
   task pwm_case(input [2:0] m, input d, input [15:0] c);
      begin
         apb(1'b1, `CTRL_OFFSET, {28'h0000000, 2'b10, d, 1'b0});
         apb(1'b1, `RELOAD_OFFSET, 32'h00000009);
         apb(1'b1, `COMPARE_OFFSET, {16'h0000, c});
         apb(1'b1, `MODE_OFFSET, 32'h00000028);
         apb(1'b1, `MODE_OFFSET, {29'h00000005, m});
         apb(1'b1, `EVENT_OFFSET, 32'h00000001);
         apb(1'b1, `CTRL_OFFSET, {28'h0000000, 2'b10, d, 1'b1});
         repeat (25) @(posedge clock_in);
         watch(100);
         check(h, model_high(m, d, c));
      end
   endtask
   // ====================
   // sequence
   initial begin
      #400000;
      n_mismatch = n_mismatch + 1;
      close_out;
   end
   initial begin
      repeat (20) @(posedge clock_in);
      reset_n_in <= 1'b1;
      apb(1'b0, `RELOAD_OFFSET, 32'h00000000);
      check(rdata, {16'h0000, `RELOAD_RESET});
      apb(1'b0, `COMPARE_OFFSET, 32'h00000000);
      check(rdata, {16'h0000, `COMPARE_RESET});
      apb(1'b0, 12'h01C, 32'h00000000);
      check(rdata, 32'h00000000);
      check(err, 1'b1);
      $display("test reset done");
      pwm_case(`CMP_PWM1, 1'b0, 16'h0004);
      pwm_case(`CMP_PWM2, 1'b0, 16'h0004);
      pwm_case(`CMP_PWM1, 1'b0, 16'h000C);
      pwm_case(`CMP_PWM1, 1'b0, 16'h0000);
      pwm_case(`CMP_PWM1, 1'b1, 16'h0004);
      pwm_case(`CMP_PWM1, 1'b1, 16'h000C);
      seed = xs(seed);
      pwm_case(`CMP_PWM1, 1'b0, 16'h0001 + seed[15:0] % 16'h0009);
      $display("test pwm done");
      apb(1'b1, `CTRL_OFFSET, 32'h00000008);
      apb(1'b1, `EVENT_OFFSET, 32'h00000001);
      apb(1'b1, `COMPARE_OFFSET, 32'h00000000);
      pin_is(1'b1);
      apb(1'b1, `EVENT_OFFSET, 32'h00000001);
      pin_is(1'b0);
      apb(1'b1, `MODE_OFFSET, 32'h00000026);
      apb(1'b1, `COMPARE_OFFSET, 32'h00000004);
      pin_is(1'b1);
      $display("test buffer done");
      apb(1'b1, `MODE_OFFSET, 32'h00000023);
      apb(1'b1, `CTRL_OFFSET, 32'h00000009);
      watch(100);
      check(t, 10);
      for (i = 0; i < 5; i = i + 1) begin
         apb(1'b1, `MODE_OFFSET, {29'h00000004, acts[3*i +: 3]});
         repeat (30) @(posedge clock_in);
         pin_is(exp5[i]);
      end
      apb(1'b1, `CTRL_OFFSET, 32'h00000008);
      apb(1'b1, `COUNT_OFFSET, 32'h00000000);
      apb(1'b0, `STATUS_OFFSET, 32'h00000000);
      check(rdata[0], 1'b1);
      apb(1'b0, `STATUS_OFFSET, 32'h00000000);
      check(rdata[0], 1'b0);
      for (i = 0; i < 4; i = i + 1) begin
         mv = 32'h00000035 - 32'h00000010 * i;
         apb(1'b1, `MODE_OFFSET, mv);
         pin_is(mv[5] ? ~mv[4] : mv[4]);
         check(channel_oe_out, mv[5]);
      end
      $display("test compare done");
      apb(1'b1, `COMPARE_OFFSET, 32'h00000003);
      apb(1'b1, `MODE_OFFSET, 32'h00006628);
      apb(1'b1, `MODE_OFFSET, 32'h0000662F);
      apb(1'b1, `EVENT_OFFSET, 32'h00000001);
      apb(1'b1, `CTRL_OFFSET, 32'h0000000C);
      watch(20);
      check(h, 0);
      @(posedge clock_in);
      fire <= 1'b1;
      @(posedge clock_in);
      fire <= 1'b0;
      watch(40);
      check(h, 7);
      apb(1'b0, `STATUS_OFFSET, 32'h00000000);
      check(rdata[3], 1'b0);
      $display("test single shot done");
      apb(1'b1, `MODE_OFFSET, 32'h00000028);
      apb(1'b1, `MODE_OFFSET, 32'h0000002E);
      apb(1'b1, `COMPARE_OFFSET, 32'h00000004);
      for (i = 1; i < 4; i = i + 2) begin
         apb(1'b1, `CTRL_OFFSET, 32'h00000008);
         apb(1'b1, `CTRL_OFFSET, 32'h00000008);
         apb(1'b1, `CTRL_OFFSET, 32'h00000008 | (i << 4));
         apb(1'b1, `EVENT_OFFSET, 32'h00000001);
         apb(1'b1, `CTRL_OFFSET, 32'h00000009 | (i << 4));
         repeat (40) @(posedge clock_in);
         watch(180);
         check(h, 80);
      end
      apb(1'b1, `CTRL_OFFSET, 32'h00000038);
      apb(1'b1, `COUNT_OFFSET, 32'h00000009);
      apb(1'b0, `STATUS_OFFSET, 32'h00000000);
      check(rdata[2], 1'b1);
      apb(1'b1, `COUNT_OFFSET, 32'h0000000C);
      apb(1'b0, `STATUS_OFFSET, 32'h00000000);
      check(rdata[2], 1'b1);
      apb(1'b1, `COUNT_OFFSET, 32'h00000000);
      apb(1'b0, `STATUS_OFFSET, 32'h00000000);
      check(rdata[2], 1'b0);
      $display("test center done");
      close_out;
   end
endmodule

// ---- test/timer_compare_pwm_sva.sv ----
// port assertions for the timer channel
// assumes: bound to timer_compare_pwm, one clock, zero wait apb
`timescale 1ns/1ps
`include "timer_pwm_regs.vh"
module timer_compare_pwm_sva #(
   parameter WIDTH = 16
) (
   input wire clock_in,
   input wire reset_n_in,
   input wire psel_in,
   input wire penable_in,
   input wire pwrite_in,
   input wire [11:0] paddr_in,
   input wire [31:0] pwdata_in,
   input wire pready_out,
   input wire pslverr_out,
   input wire [31:0] prdata_out,
   input wire input2_filtered_edge_in,
   input wire channel_out,
   input wire channel_oe_out,
   input wire compare_flag_out
);
   // ====================
   // helpers
   wire acc = psel_in && penable_in;
   wire rd = acc && !pwrite_in;
   wire mapped = (paddr_in <= `STATUS_OFFSET) && (paddr_in[1:0] == 2'h0);
   wire mode_wr = acc && pwrite_in && (paddr_in == `MODE_OFFSET);
   wire st_rd = psel_in && !pwrite_in && (paddr_in == `STATUS_OFFSET);
   reg [1:0] since_mode_reg;
   always @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         since_mode_reg <= 2'h0;
      end else if (mode_wr) begin
         since_mode_reg <= 2'h0;
      end else if (since_mode_reg != 2'h3) begin
         since_mode_reg <= since_mode_reg + 2'h1;
      end
   end
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!reset_n_in);
   // ====================
   // assertions
   ready_always_a: assert property (pready_out)
      else $error("ready low");
   unmapped_err_a: assert property (acc && !mapped |-> pslverr_out)
      else $error("no error on unmapped access");
   mapped_ok_a: assert property (!(acc && !mapped) |-> !pslverr_out)
      else $error("error without unmapped access");
   unmapped_zero_a: assert property (rd && !mapped |-> prdata_out == 32'h00000000)
      else $error("unmapped read not zero");
   oe_follow_a: assert property (mode_wr ##1 !mode_wr |=>
      channel_oe_out == $past(pwdata_in[`MODE_OEN_BIT], 2)) else $error("enable not taken");
   quiet_pin_a: assert property (!channel_oe_out && $past(!channel_oe_out) &&
      since_mode_reg == 2'h3 |-> $stable(channel_out)) else $error("disabled pin moved");
   status_rsvd_a: assert property (rd && paddr_in == `STATUS_OFFSET |->
      prdata_out[31:4] == 28'h0000000) else $error("status reserved bits set");
   data_width_a: assert property (rd && paddr_in == `RELOAD_OFFSET |->
      prdata_out[31:WIDTH] == 0) else $error("reload upper bits set");
   flag_clear_a: assert property ($fell(compare_flag_out) |-> $past(st_rd) || $past(st_rd, 2))
      else $error("flag cleared without status read");
endmodule
bind timer_compare_pwm timer_compare_pwm_sva #(.WIDTH(WIDTH)) u_sva (.clock_in(clock_in),
   .reset_n_in(reset_n_in), .psel_in(psel_in), .penable_in(penable_in),
   .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
   .pready_out(pready_out), .pslverr_out(pslverr_out), .prdata_out(prdata_out),
   .input2_filtered_edge_in(input2_filtered_edge_in), .channel_out(channel_out),
   .channel_oe_out(channel_oe_out), .compare_flag_out(compare_flag_out));

// ---- test/trig_partner.sv ----
// trigger source standing at the channel's far side
// assumes: requests arrive synchronous to clock_in
`timescale 1ns/1ps
module trig_partner (
   input wire clock_in,
   input wire fire_in,
   output reg trig_out
);
   reg [1:0] hold_reg = 2'h0;
   initial trig_out = 1'b0;
   always @(posedge clock_in) begin
      hold_reg <= fire_in ? 2'h3 : hold_reg - (hold_reg != 2'h0);
      trig_out <= fire_in || (hold_reg != 2'h0);
   end
endmodule
